// *** common/mtc_pkg.sv ***
// Shared constants and types of the modem configuration register bank
package mtc_pkg;

	// Widths of the serial port, the registers and the coefficient table
	localparam int ADDR_W   = 7;
	localparam int DATA_W   = 8;
	localparam int COEF_W   = 6;
	localparam int COEF_N   = 7;
	localparam int IDX_W    = 3;
	localparam int TXPOW_W  = 2;
	localparam int CODING_W = 6;
	localparam int CNT_W    = 3;

	// Register offsets on the serial port
	localparam logic [ADDR_W-1:0] ADDR_AGC2     = 7'h6A;
	localparam logic [ADDR_W-1:0] ADDR_COEF_IDX = 7'h6B;
	localparam logic [ADDR_W-1:0] ADDR_COEF_VAL = 7'h6C;
	localparam logic [ADDR_W-1:0] ADDR_TXPOW    = 7'h6D;
	localparam logic [ADDR_W-1:0] ADDR_RATE_HI  = 7'h6E;
	localparam logic [ADDR_W-1:0] ADDR_RATE_LO  = 7'h6F;
	localparam logic [ADDR_W-1:0] ADDR_CODING   = 7'h70;
	localparam logic [ADDR_W-1:0] ADDR_STEP     = 7'h01;

	// Field positions of the gain-override register
	localparam int AGC_IGN_PRE  = 7;
	localparam int AGC_SLOW     = 6;
	localparam int LNA_COMP_LSB = 2;
	localparam int LNA_COMP_W   = 4;
	localparam int PGA_REF_LSB  = 0;
	localparam int PGA_REF_W    = 2;

	// Field positions of the coding control register
	localparam int CODE_SCALE = 5;
	localparam int PH_PWDN    = 4;
	localparam int MAN_PPOL   = 3;
	localparam int MAN_INV    = 2;
	localparam int MAN_EN     = 1;
	localparam int WHITE_EN   = 0;

	// Header bit that marks a write
	localparam int HDR_WRITE_BIT = 7;

	// Reset values, unmapped read value and bit counter constants
	localparam logic [DATA_W-1:0]   RST_AGC2     = 8'h00;
	localparam logic [IDX_W-1:0]    RST_COEF_IDX = 3'h0;
	localparam logic [TXPOW_W-1:0]  RST_TXPOW    = 2'h3;
	localparam logic [DATA_W-1:0]   RST_RATE_HI  = 8'h0A;
	localparam logic [DATA_W-1:0]   RST_RATE_LO  = 8'h0D;
	localparam logic [CODING_W-1:0] RST_CODING   = 6'h00;
	localparam logic [DATA_W-1:0]   RD_UNMAPPED  = 8'h00;
	localparam logic [CNT_W-1:0]    CNT_LAST     = 3'h7;
	localparam logic [CNT_W-1:0]    CNT_STEP     = 3'h1;

	// Gaussian coefficient defaults, entry 0 in the low bits
	localparam logic [COEF_N*COEF_W-1:0] COEF_RST = {
		6'h14, 6'h13, 6'h0F, 6'h0A, 6'h06, 6'h03, 6'h01
	};
	localparam logic [COEF_W-1:0] COEF_RST_E0 = 6'h01;

	// Serial frame states, Gray along idle, header, data
	typedef enum logic [1:0] {
		SPI_IDLE = 2'b00,
		SPI_HDR  = 2'b01,
		SPI_DATA = 2'b11
	} mtc_spi_st_t;

endpackage : mtc_pkg

// *** hdl/mtc_coef_mem.sv ***
// Gaussian coefficient table with one write port and two registered read ports
`timescale 1ns/100ps
`default_nettype none

module mtc_coef_mem #(
	parameter int                   W   = mtc_pkg::COEF_W,
	parameter int                   N   = mtc_pkg::COEF_N,
	parameter int                   AW  = mtc_pkg::IDX_W,
	parameter logic [N*W-1:0]       RST = mtc_pkg::COEF_RST
) (
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [W-1:0]  i_wdata,
	input  wire logic [AW-1:0] i_raddr_a,
	output logic      [W-1:0]  o_rdata_a,
	input  wire logic [AW-1:0] i_raddr_b,
	output logic      [W-1:0]  o_rdata_b
);
	import mtc_pkg::*;

	typedef struct packed {
		logic [N-1:0][W-1:0] mem;
		logic [W-1:0]        rd_a;
		logic [W-1:0]        rd_b;
	} mtc_mem_state_t;

	mtc_mem_state_t q;
	mtc_mem_state_t next_q;

	// Entries past the table read as zero; writes there are dropped
	function automatic logic [W-1:0] rd_entry(input logic [N-1:0][W-1:0] m,
	                                          input logic [AW-1:0] a);
		rd_entry = (int'(a) < N) ? m[a] : '0;
	endfunction : rd_entry

	// Next state: reset loads the default table
	always_comb begin
		next_q      = q;
		next_q.rd_a = rd_entry(q.mem, i_raddr_a);
		next_q.rd_b = rd_entry(q.mem, i_raddr_b);
		if (i_we && (int'(i_waddr) < N)) begin
			next_q.mem[i_waddr] = i_wdata;
		end
		if (i_rst) begin
			next_q.mem  = RST;
			next_q.rd_a = '0;
			next_q.rd_b = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		q <= next_q;
	end

	assign o_rdata_a = q.rd_a;
	assign o_rdata_b = q.rd_b;

endmodule : mtc_coef_mem

`default_nettype wire

// *** hdl/mtc_regs.sv ***
// Modem transmit and receive-gain configuration register bank behind the serial register port
//
// Overview of operation
// RL1: Preamble-ignore bit makes gain control ignore preamble
// RL2: Slow-rise bit slows gain increase only
// RL3: LNA compensation field smooths signal strength
// RL4: Two-bit field drives window comparator reference
// RL5: Three-bit index selects coefficient entries 0..6
// RL6: Reset loads coefficients 1,3,6,10,15,19,20
// RL7: Host loads coefficients only for other shaping
// RL8: Value field reads and writes indexed entry
// RL9: Two-bit code selects transmit power level
// RL10: Sixteen-bit rate word with scale bit
// RL11: Host sets scale bit below 30 kbps
// RL12: Packet handler powers down in low power
// RL13: Manchester preamble polarity, transmit side only
// RL14: Bit 2 enables Manchester data inversion
// RL15: Bit 1 enables Manchester coding
// RL16: Bit 0 enables data whitening
// RL17: Host writes and reads registers over serial port
// RL18: Reserved bits ignore writes, read zero
`timescale 1ns/100ps
`default_nettype none

module mtc_regs (
	input  wire logic                           i_clk,
	input  wire logic                           i_rst,
	input  wire logic                           i_sclk,
	input  wire logic                           i_sel_n,
	input  wire logic                           i_sdi,
	output logic                                o_sdo,
	output logic                                o_sdo_oe,
	input  wire logic                           i_low_power_mode,
	input  wire logic [mtc_pkg::IDX_W-1:0]      i_coef_sel,
	output logic      [mtc_pkg::COEF_W-1:0]     o_coef_data,
	output logic                                o_agc_ignore_preamble,
	output logic                                o_agc_slow_rise,
	output logic      [mtc_pkg::LNA_COMP_W-1:0] o_lna_gain_comp,
	output logic      [mtc_pkg::PGA_REF_W-1:0]  o_pga_window_ref,
	output logic      [mtc_pkg::TXPOW_W-1:0]    o_tx_power_code,
	output logic      [2*mtc_pkg::DATA_W-1:0]   o_tx_rate_word,
	output logic                                o_tx_rate_scale,
	output logic                                o_ph_powerdown,
	output logic                                o_tx_preamble_ones,
	output logic                                o_manch_invert,
	output logic                                o_manch_en,
	output logic                                o_whiten_en
);
	import mtc_pkg::*;

	typedef struct packed {
		logic                sclk_m;
		logic                sclk_s;
		logic                sclk_d;
		logic                sel_m;
		logic                sel_s;
		logic                sdi_m;
		logic                sdi_s;
		mtc_spi_st_t         st;
		logic [CNT_W-1:0]    bit_cnt;
		logic [DATA_W-1:0]   rx_sh;
		logic                rw;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   tx_sh;
		logic                sdo;
		logic                sdo_oe;
		logic [DATA_W-1:0]   agc2;
		logic [IDX_W-1:0]    coef_idx;
		logic [TXPOW_W-1:0]  txpow;
		logic [DATA_W-1:0]   rate_hi;
		logic [DATA_W-1:0]   rate_lo;
		logic [CODING_W-1:0] coding;
		logic                ph_pwdn;
		logic                pre_ones;
	} mtc_state_t;

	mtc_state_t               q;
	mtc_state_t               next_q;
	logic                     rise;
	logic                     fall;
	logic [DATA_W-1:0]        rx_byte;
	logic                     wr_en;
	logic                     coef_we;
	logic [COEF_W-1:0]        coef_rdata;

	// Read-back of one register; reserved and unmapped bits read zero
	function automatic logic [DATA_W-1:0] rd_mux(input mtc_state_t s,
	                                             input logic [ADDR_W-1:0] a,
	                                             input logic [COEF_W-1:0] cv);
		case (a)
			ADDR_AGC2:     rd_mux = s.agc2;
			ADDR_COEF_IDX: rd_mux = {{(DATA_W-IDX_W){1'b0}}, s.coef_idx};   // [RL18]
			ADDR_COEF_VAL: rd_mux = {{(DATA_W-COEF_W){1'b0}}, cv};          // [RL8]
			ADDR_TXPOW:    rd_mux = {{(DATA_W-TXPOW_W){1'b0}}, s.txpow};    // [RL18]
			ADDR_RATE_HI:  rd_mux = s.rate_hi;
			ADDR_RATE_LO:  rd_mux = s.rate_lo;
			ADDR_CODING:   rd_mux = {{(DATA_W-CODING_W){1'b0}}, s.coding};  // [RL18]
			default:       rd_mux = RD_UNMAPPED;
		endcase
	endfunction : rd_mux

	// Coefficient table; port a serves the host, port b the shaping filter
	mtc_coef_mem #(
		.W   (COEF_W),
		.N   (COEF_N),
		.AW  (IDX_W),
		.RST (COEF_RST)                                                    // [RL6]
	) u_coef_mem (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_we      (coef_we),
		.i_waddr   (q.coef_idx),
		.i_wdata   (rx_byte[COEF_W-1:0]),
		.i_raddr_a (q.coef_idx),                                           // [RL5]
		.o_rdata_a (coef_rdata),
		.i_raddr_b (i_coef_sel),
		.o_rdata_b (o_coef_data)
	);

	// Edges of the synchronised serial clock; the second stage is compared with its delayed third stage
	assign rise    = q.sclk_s & ~q.sclk_d;
	assign fall    = ~q.sclk_s & q.sclk_d;
	assign rx_byte = {q.rx_sh[DATA_W-2:0], q.sdi_s};
	assign wr_en   = rise && (q.st == SPI_DATA) && q.rw && (q.bit_cnt == CNT_LAST);
	assign coef_we = wr_en && (q.addr == ADDR_COEF_VAL);                   // [RL8]

	// Serial frame engine and register writes
	always_comb begin
		next_q        = q;
		next_q.sclk_m = i_sclk;
		next_q.sclk_s = q.sclk_m;
		next_q.sclk_d = q.sclk_s;
		next_q.sel_m  = i_sel_n;
		next_q.sel_s  = q.sel_m;
		next_q.sdi_m  = i_sdi;
		next_q.sdi_s  = q.sdi_m;
		if (q.sel_s) begin
			// Deselect aborts any frame; a half byte is dropped
			next_q.st     = SPI_IDLE;
			next_q.sdo_oe = 1'b0;
			next_q.sdo    = 1'b0;
		end else begin
			case (q.st)
				SPI_IDLE: begin
					next_q.st      = SPI_HDR;
					next_q.bit_cnt = '0;
					next_q.tx_sh   = '0;
					next_q.sdo     = 1'b0;
					next_q.sdo_oe  = 1'b1;                                 // [RL17]
				end
				SPI_HDR, SPI_DATA: begin
					if (rise) begin
						next_q.rx_sh   = rx_byte;
						next_q.bit_cnt = q.bit_cnt + CNT_STEP;
						if (q.bit_cnt == CNT_LAST) begin
							if (q.st == SPI_HDR) begin
								next_q.st   = SPI_DATA;
								next_q.rw   = rx_byte[HDR_WRITE_BIT];
								next_q.addr = rx_byte[ADDR_W-1:0];
								next_q.tx_sh = rd_mux(q, rx_byte[ADDR_W-1:0], coef_rdata);
							end else begin
								// Bursts step to the next offset
								next_q.addr  = q.addr + ADDR_STEP;
								next_q.tx_sh = rd_mux(q, q.addr + ADDR_STEP, coef_rdata);
							end
						end
					end else if (fall) begin
						next_q.sdo   = q.tx_sh[DATA_W-1];                      // [RL17]
						next_q.tx_sh = {q.tx_sh[DATA_W-2:0], 1'b0};
					end
				end
				default: begin
					next_q.st = SPI_IDLE;
				end
			endcase
		end
		// Writes keep only defined fields; reserved bits are dropped
		if (wr_en) begin
			case (q.addr)
				ADDR_AGC2:     next_q.agc2     = rx_byte;                  // [RL1] [RL2] [RL3] [RL4]
				ADDR_COEF_IDX: next_q.coef_idx = rx_byte[IDX_W-1:0];       // [RL5] [RL18]
				ADDR_TXPOW:    next_q.txpow    = rx_byte[TXPOW_W-1:0];     // [RL9] [RL18]
				ADDR_RATE_HI:  next_q.rate_hi  = rx_byte;                  // [RL10]
				ADDR_RATE_LO:  next_q.rate_lo  = rx_byte;                  // [RL10]
				ADDR_CODING:   next_q.coding   = rx_byte[CODING_W-1:0];    // [RL18]
				default:       next_q.coding   = q.coding;
			endcase
		end
		// Power-down only while both the option and low power hold
		next_q.ph_pwdn  = q.coding[PH_PWDN] & i_low_power_mode;            // [RL12]
		// Polarity matters only with Manchester coding on
		next_q.pre_ones = q.coding[MAN_EN] & q.coding[MAN_PPOL];           // [RL13]
		if (i_rst) begin
			next_q          = '0;
			next_q.sclk_m   = 1'b0;
			next_q.sel_m    = 1'b1;
			next_q.sel_s    = 1'b1;
			next_q.st       = SPI_IDLE;
			next_q.agc2     = RST_AGC2;
			next_q.coef_idx = RST_COEF_IDX;
			next_q.txpow    = RST_TXPOW;
			next_q.rate_hi  = RST_RATE_HI;
			next_q.rate_lo  = RST_RATE_LO;
			next_q.coding   = RST_CODING;
		end
	end

	always_ff @(posedge i_clk) begin
		q <= next_q;
	end

	// Configuration outputs straight from register bits
	assign o_sdo                 = q.sdo;
	assign o_sdo_oe              = q.sdo_oe;
	assign o_agc_ignore_preamble = q.agc2[AGC_IGN_PRE];                              // [RL1]
	assign o_agc_slow_rise       = q.agc2[AGC_SLOW];                                 // [RL2]
	assign o_lna_gain_comp       = q.agc2[LNA_COMP_LSB +: LNA_COMP_W];               // [RL3]
	assign o_pga_window_ref      = q.agc2[PGA_REF_LSB +: PGA_REF_W];                 // [RL4]
	assign o_tx_power_code       = q.txpow;                                          // [RL9]
	assign o_tx_rate_word        = {q.rate_hi, q.rate_lo};                           // [RL10]
	assign o_tx_rate_scale       = q.coding[CODE_SCALE];                             // [RL10]
	assign o_ph_powerdown        = q.ph_pwdn;
	assign o_tx_preamble_ones    = q.pre_ones;
	assign o_manch_invert        = q.coding[MAN_INV];                                // [RL14]
	assign o_manch_en            = q.coding[MAN_EN];                                 // [RL15]
	assign o_whiten_en           = q.coding[WHITE_EN];                               // [RL16]

	// Checks on the register behaviour
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	property p_agc_ignore;
		wr_en && (q.addr == ADDR_AGC2) |=> o_agc_ignore_preamble == $past(rx_byte[AGC_IGN_PRE]);
	endproperty
	a_agc_ignore: assert property (p_agc_ignore) else $error("preamble ignore wrong"); // [RL1]
	property p_agc_slow;
		wr_en && (q.addr == ADDR_AGC2) |=> o_agc_slow_rise == $past(rx_byte[AGC_SLOW]);
	endproperty
	a_agc_slow: assert property (p_agc_slow) else $error("slow rise wrong"); // [RL2]
	property p_lna_comp;
		!(wr_en && (q.addr == ADDR_AGC2)) |=> $stable(o_lna_gain_comp);
	endproperty
	a_lna_comp: assert property (p_lna_comp) else $error("lna comp moved"); // [RL3]
	// Stability alone would pass a field that never loads
	property p_lna_write;
		wr_en && (q.addr == ADDR_AGC2) |=> o_lna_gain_comp
			== $past(rx_byte[LNA_COMP_LSB +: LNA_COMP_W]);
	endproperty
	a_lna_write: assert property (p_lna_write) else $error("lna comp not loaded"); // [RL3]
	property p_pga_ref;
		wr_en && (q.addr == ADDR_AGC2) |=> o_pga_window_ref
			== $past(rx_byte[PGA_REF_LSB +: PGA_REF_W]);
	endproperty
	a_pga_ref: assert property (p_pga_ref) else $error("pga ref wrong"); // [RL4]
	property p_coef_reset;
		$fell(i_rst) |-> ##1 (coef_rdata == COEF_RST_E0);
	endproperty
	a_coef_reset: assert property (@(posedge i_clk) p_coef_reset) else $error("coef default"); // [RL6]
	property p_coef_write;
		coef_we && (int'(q.coef_idx) < COEF_N) |-> ##2
			(coef_rdata == $past(rx_byte[COEF_W-1:0], 2));
	endproperty
	a_coef_write: assert property (p_coef_write) else $error("coef write lost"); // [RL8]
	property p_tx_power;
		wr_en && (q.addr == ADDR_TXPOW) |=> o_tx_power_code == $past(rx_byte[TXPOW_W-1:0]);
	endproperty
	a_tx_power: assert property (p_tx_power) else $error("tx power wrong"); // [RL9]
	property p_rate_hi;
		wr_en && (q.addr == ADDR_RATE_HI) |=> (o_tx_rate_word[DATA_W +: DATA_W]
			== $past(rx_byte)) && $stable(o_tx_rate_word[DATA_W-1:0]);
	endproperty
	a_rate_hi: assert property (p_rate_hi) else $error("rate high byte wrong"); // [RL10]
	property p_rate_scale;
		wr_en && (q.addr == ADDR_CODING) |=> o_tx_rate_scale == $past(rx_byte[CODE_SCALE]);
	endproperty
	a_rate_scale: assert property (p_rate_scale) else $error("rate scale wrong"); // [RL10]
	property p_ph_pwdn;
		(q.coding[PH_PWDN] && i_low_power_mode) |=> o_ph_powerdown;
	endproperty
	a_ph_pwdn: assert property (p_ph_pwdn) else $error("no power down"); // [RL12]
	property p_ph_awake;
		!i_low_power_mode |=> !o_ph_powerdown;
	endproperty
	a_ph_awake: assert property (p_ph_awake) else $error("power down when awake"); // [RL12]
	property p_preamble;
		!o_manch_en ##1 !o_manch_en |-> !o_tx_preamble_ones;
	endproperty
	a_preamble: assert property (p_preamble) else $error("preamble without manchester"); // [RL13]
	property p_coding;
		wr_en && (q.addr == ADDR_CODING) |=> {o_manch_invert, o_manch_en, o_whiten_en}
			== $past(rx_byte[MAN_INV:WHITE_EN]);
	endproperty
	a_coding: assert property (p_coding) else $error("coding bits wrong"); // [RL14] [RL15] [RL16]
	property p_reserved;
		rise && (q.st == SPI_HDR) && (q.bit_cnt == CNT_LAST)
			&& (rx_byte[ADDR_W-1:0] == ADDR_CODING) |=> q.tx_sh[DATA_W-1:CODING_W] == '0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [RL18]
	property p_deselect;
		q.sel_s |=> !o_sdo_oe;
	endproperty
	a_deselect: assert property (p_deselect) else $error("sdo driven while deselected"); // [RL17]
	// A selected host must find the data line driven
	property p_select_drive;
		!q.sel_s |=> o_sdo_oe;
	endproperty
	a_select_drive: assert property (p_select_drive) else $error("sdo not driven"); // [RL17]

endmodule : mtc_regs

`default_nettype wire

// *** tb/mtc_host_model.sv ***
// Host microcontroller model driving the serial register port
`timescale 1ns/100ps
`default_nettype none

module mtc_host_model (
	input  wire logic i_clk,
	output logic      o_sclk,
	output logic      o_sel_n,
	output logic      o_sdi,
	input  wire logic i_sdo
);
	// Half period of sclk, kept above the three-cycle minimum
	localparam int PH = 6;

	// Idle pins: clock low, device deselected
	initial begin
		o_sclk  = 1'b0;
		o_sel_n = 1'b1;
		o_sdi   = 1'b0;
	end

	// Wait n system edges, then step just off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick

	// One byte MSB first; sdi moves while sclk is low, sdo taken just before the rise
	task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			o_sdi = tx[i];
			tick(PH);
			rx[i] = i_sdo;
			o_sclk = 1'b1;
			tick(PH);
			o_sclk = 1'b0;
		end
	endtask : shift

	// Header then one data byte; sdi is not left showing its last bit when idle
	task automatic frame(input logic wr, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [7:0] hq;
		o_sel_n = 1'b0;
		tick(PH);
		shift({wr, a}, hq);
		shift(d, q);
		tick(PH);
		o_sel_n = 1'b1;
		o_sdi = ~o_sdi;
		tick(PH);
	endtask : frame

	// Register write, header bit 7 set
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		frame(1'b1, a, d, q);
	endtask : wr

	// Register read, data byte sent as zeros
	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		frame(1'b0, a, 8'h00, q);
	endtask : rd

endmodule : mtc_host_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench of the modem configuration register bank
`timescale 1ns/100ps
`default_nettype none

module tb;
	import mtc_pkg::*;

	localparam int TIMEOUT = 40000;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sclk;
	logic        sel_n;
	logic        sdi;
	logic        sdo;
	logic        sdo_oe;
	logic        sdo_pin;
	logic        lpm = 1'b0;
	logic [2:0]  coef_sel = 3'h0;
	logic [5:0]  coef_data;
	logic        agc_ign;
	logic        agc_slow;
	logic [3:0]  lna;
	logic [1:0]  pga;
	logic [1:0]  txpow;
	logic [15:0] rate;
	logic        scale;
	logic        ph_pd;
	logic        pre1;
	logic        minv;
	logic        men;
	logic        wen;
	int          miscompares = 0;
	int          n_checks = 0;
	int          cycles = 0;

	// 25 MHz system clock
	always #20 clk = ~clk;

	mtc_regs dut_u (
		.i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_sel_n(sel_n), .i_sdi(sdi),
		.o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_low_power_mode(lpm),
		.i_coef_sel(coef_sel), .o_coef_data(coef_data),
		.o_agc_ignore_preamble(agc_ign), .o_agc_slow_rise(agc_slow),
		.o_lna_gain_comp(lna), .o_pga_window_ref(pga), .o_tx_power_code(txpow),
		.o_tx_rate_word(rate), .o_tx_rate_scale(scale), .o_ph_powerdown(ph_pd),
		.o_tx_preamble_ones(pre1), .o_manch_invert(minv), .o_manch_en(men),
		.o_whiten_en(wen)
	);

	// Undriven line shows the inverse, so a missing enable corrupts reads
	assign sdo_pin = sdo_oe ? sdo : ~sdo;

	mtc_host_model host_u (
		.i_clk(clk), .o_sclk(sclk), .o_sel_n(sel_n), .o_sdi(sdi), .i_sdo(sdo_pin)
	);

	task automatic end_of_test();
		if (miscompares == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// Reset contents of every register, plus one unmapped place
	task automatic t_reset();
		logic [7:0] q;
		logic [6:0] a [8] = '{ADDR_AGC2, ADDR_COEF_IDX, ADDR_COEF_VAL, ADDR_TXPOW,
			ADDR_RATE_HI, ADDR_RATE_LO, ADDR_CODING, 7'h71};
		logic [7:0] e [8] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'h0A, 8'h0D, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			host_u.rd(a[i], q);
			check("reset read", q, e[i]);
		end
		check("rate word", rate, 16'h0A0D);
		check("power code", txpow, 2'h3);
		check("sdo enable idle", sdo_oe, 1'b0);
	endtask : t_reset

	// Every table entry: default, reload with reserved bits set, filter port
	task automatic t_coef();
		logic [7:0] q;
		logic [5:0] v;
		logic [5:0] dflt [7] = '{6'h01, 6'h03, 6'h06, 6'h0A, 6'h0F, 6'h13, 6'h14};
		for (int i = 0; i < 7; i++) begin
			v = 6'h2A ^ 6'(i);
			host_u.wr(ADDR_COEF_IDX, 8'hF8 | 8'(i));
			host_u.rd(ADDR_COEF_IDX, q);
			check("coef index", q, 16'(i));
			host_u.rd(ADDR_COEF_VAL, q);
			check("coef default", q, {2'b00, dflt[i]});
			// Reload only because a shaping other than the default is wanted
			host_u.wr(ADDR_COEF_VAL, {2'b11, v});
			host_u.rd(ADDR_COEF_VAL, q);
			check("coef reload", q, {2'b00, v});
			coef_sel = 3'(i);
			step(2);
			check("coef port", coef_data, v);
		end
		host_u.wr(ADDR_COEF_IDX, 8'h07);
		host_u.rd(ADDR_COEF_VAL, q);
		check("coef index 7", q, 8'h00);
	endtask : t_coef

	// Gain override fields reach their outputs
	task automatic t_agc(input logic [7:0] d);
		logic [7:0] q;
		host_u.wr(ADDR_AGC2, d);
		host_u.rd(ADDR_AGC2, q);
		check("agc read", q, d);
		check("ignore preamble", agc_ign, d[7]);
		check("slow rise", agc_slow, d[6]);
		check("lna comp", lna, d[5:2]);
		check("pga ref", pga, d[1:0]);
	endtask : t_agc

	// All four power codes, upper bits written as ones
	task automatic t_power();
		logic [7:0] q;
		for (int c = 0; c < 4; c++) begin
			host_u.wr(ADDR_TXPOW, 8'hFC | 8'(c));
			host_u.rd(ADDR_TXPOW, q);
			check("power read", q, 16'(c));
			check("power code", txpow, 16'(c));
		end
	endtask : t_power

	// Both rate bytes land in the word; a slow rate goes with the scale bit
	task automatic t_rate();
		host_u.wr(ADDR_RATE_HI, 8'h12);
		host_u.wr(ADDR_RATE_LO, 8'h34);
		check("rate word", rate, 16'h1234);
		host_u.wr(ADDR_CODING, 8'h20);
		check("rate scale", scale, 1'b1);
	endtask : t_rate

	// Walking one through the coding bits, then the gated combinations
	task automatic t_coding();
		logic [7:0] q;
		logic [5:0] b;
		for (int i = 0; i < 6; i++) begin
			b = 6'h01 << i;
			host_u.wr(ADDR_CODING, {2'b11, b});
			host_u.rd(ADDR_CODING, q);
			check("coding read", q, {2'b00, b});
			check("coding outs", {scale, ph_pd, pre1, minv, men, wen},
				{b[5], 2'b00, b[2:0]});
		end
		host_u.wr(ADDR_CODING, 8'h10);
		lpm = 1'b1;
		step(2);
		check("ph powerdown", ph_pd, 1'b1);
		lpm = 1'b0;
		step(2);
		check("ph awake", ph_pd, 1'b0);
		host_u.wr(ADDR_CODING, 8'h0A);
		check("preamble ones", {pre1, men}, 2'b11);
		host_u.wr(ADDR_CODING, 8'h02);
		check("preamble zeros", {pre1, men}, 2'b01);
	endtask : t_coding

	// Hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == TIMEOUT) begin
			miscompares++;
			end_of_test();
		end
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		step(4);
		t_reset();
		t_coef();
		t_agc(8'hA5);
		t_agc(8'h5A);
		t_power();
		t_rate();
		t_coding();
		end_of_test();
	end

endmodule : tb
`default_nettype wire
